/* File: pkg/cca_map.svh */
// Constants for the core access unit: indices, system register offsets,
// field positions, reset values and memory map.
// Assumes inclusion by bare name from every file that needs a number.
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH
`define CCA_RF_ENTRIES 16
`define CCA_RETVAL_IDX 4'hC
`define CCA_PC_IDX     4'hF
`define CCA_PC_RESET   32'h0000_0000
`define CCA_SR_CPU_CONTROL_REGISTER   10'h00C
`define CCA_SR_CFG0    10'h100
`define CCA_SR_MPUAR0  10'h140
`define CCA_CPU_CONTROL_REGISTER_LBEN 0
`define CCA_CPU_CONTROL_REGISTER_MPEN 1
`define CCA_CFG0_REV_LSB 13
`define CCA_ARCH_REV   3'h3
`define CCA_RAM_BASE   32'h0000_0000
`define CCA_RAM_MASK   32'hFFFF_0000
`define CCA_LB_BASE    32'hFFFE_0000
`define CCA_LB_MASK    32'hFFFF_0000
`define CCA_MPU_BASE_MASK 32'hFFFF_F000
`define CCA_DW_STEP    32'h0000_0004
`define CCA_PC_STEP    32'h0000_0004
`endif

/* File: pkg/cca_pkg.sv */
// Types for the core access unit: instruction classes, sizes, states.
// Assumes the numeric constants come from cca_map.svh.
package cca_pkg;
  // Decoded instruction class offered by the front end
  typedef enum logic [3:0] {
    CCA_NOP, CCA_LOAD, CCA_STORE, CCA_LOAD_D, CCA_STORE_D, CCA_MFSR,
    CCA_MTSR, CCA_SIMD, CCA_COPRO, CCA_BYTECODE, CCA_TLB, CCA_CACHE
  } cca_insn_t;
  // Access size codes
  typedef enum logic [1:0] {CCA_BYTE, CCA_HALF, CCA_WORD, CCA_SZ_RSV} cca_size_t;
  // Sequencer states
  typedef enum logic [1:0] {CCA_IDLE, CCA_ISSUE, CCA_RDATA} cca_state_t;
  // Where a data access goes
  typedef enum logic [1:0] {CCA_T_RAM, CCA_T_LB, CCA_T_HSB} cca_tgt_t;
endpackage : cca_pkg

/* File: hw/cca_core.sv */
// Data access unit of a small 32-bit core: register file, fetch master,
// data routing to RAM port, local bus and high speed bus, RAM slave port.
// Assumes a decoded instruction stream and single-clock surroundings.
`timescale 1ns/10ps
`include "cca_map.svh"

// Functional notes
// RULE1: Sixteen 32-bit registers including PC, LR, SP
// RULE2: Register twelve holds return value implicitly
// RULE3: Fetch master, data master, RAM slave port
// RULE4: Internal RAM over dedicated low-latency port
// RULE5: No caches, no bytecode hardware; MPU present
// RULE6: Local bus unusable until enable bit set
// RULE7: Local bus transfer completes in one cycle
// RULE8: Local range decoded from ordinary loads/stores
// RULE9: Double-word transfers need only word alignment
// RULE10: Other accesses naturally aligned to size
// RULE11: Unimplemented classes raise unimplemented exception
// RULE12: Read-only revision 3 field in config word
// RULE13: Misaligned access aborted, exception, nothing changed
module cca_core #(
  parameter int MPU_REGIONS = 8          // Protection regions
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_B_I,
  input  wire logic        INSN_VALID_I,   // Instruction offered
  input  wire logic [3:0]  INSN_CLASS_I,   // cca_insn_t code
  input  wire logic [1:0]  ACC_SIZE_I,     // cca_size_t code
  input  wire logic [31:0] ACC_ADDR_I,     // Address or sysreg offset
  input  wire logic [3:0]  ACC_SRC_I,      // Store / mtsr source
  input  wire logic [3:0]  ACC_DST_I,      // Load / mfsr destination
  input  wire logic        COPRO_PRESENT_I,
  output logic             BUSY_O,
  output logic             DONE_O,
  output logic             EXC_UNIMPL_O,
  output logic             EXC_ALIGN_O,
  output logic             EXC_PROT_O,
  output logic             EXC_LBOFF_O,
  output logic [31:0]      EXC_ADDR_O,
  input  wire logic        RETVAL_WE_I,
  input  wire logic [31:0] RETVAL_DATA_I,
  output logic [31:0]      RETVAL_O,
  input  wire logic        FETCH_EN_I,
  output logic             IF_REQ_O,
  output logic [31:0]      IF_ADDR_O,
  input  wire logic        IF_READY_I,
  input  wire logic [31:0] IF_RDATA_I,
  output logic [31:0]      FETCH_DATA_O,
  output logic             FETCH_VALID_O,
  output logic             HSBD_REQ_O,
  input  wire logic        HSBD_READY_I,
  input  wire logic [31:0] HSBD_RDATA_I,
  output logic             LB_REQ_O,
  input  wire logic [31:0] LB_RDATA_I,
  output logic             MEM_WE_O,
  output logic [31:0]      MEM_ADDR_O,
  output logic [3:0]       MEM_BE_O,
  output logic [31:0]      MEM_WDATA_O,
  output logic             RAM_REQ_O,
  output logic             RAM_WE_O,
  output logic [31:0]      RAM_ADDR_O,
  output logic [3:0]       RAM_BE_O,
  output logic [31:0]      RAM_WDATA_O,
  input  wire logic [31:0] RAM_RDATA_I,
  input  wire logic        HSBS_SEL_I,
  input  wire logic        HSBS_WE_I,
  input  wire logic [31:0] HSBS_ADDR_I,
  input  wire logic [3:0]  HSBS_BE_I,
  input  wire logic [31:0] HSBS_WDATA_I,
  output logic             HSBS_READY_O,
  output logic             HSBS_RVALID_O,
  output logic [31:0]      HSBS_RDATA_O
);

  // Architectural state
  logic [31:0] rf_reg [`CCA_RF_ENTRIES];   // General registers
  logic [31:0] rf_next [`CCA_RF_ENTRIES];
  logic [31:0] mpuar_reg [MPU_REGIONS];    // Region descriptors
  logic        lben_reg;                   // Local bus enable bit
  logic        mpen_reg;                   // Protection enable bit
  // Sequencer state
  cca_pkg::cca_state_t state_reg;
  cca_pkg::cca_tgt_t   tgt_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  be_reg;
  logic [3:0]  dst_reg;
  logic [3:0]  src_reg;
  logic [1:0]  size_reg;
  logic        we_reg;
  logic        dw_reg;       // Double-word transfer
  logic        second_reg;   // Working on the upper word
  logic        done_reg;
  logic        exc_unimpl_reg;
  logic        exc_align_reg;
  logic        exc_prot_reg;
  logic        exc_lboff_reg;
  logic [31:0] exc_addr_reg;
  logic [31:0] fetch_data_reg;
  logic        fetch_valid_reg;
  logic        hsbs_rvalid_reg;

  // Decode of the offered instruction
  cca_pkg::cca_insn_t cls;
  cca_pkg::cca_size_t size_eff;
  logic        take, is_mem, is_dw, is_wr, unimpl, misalign;
  logic        in_ram, in_lb, mpu_ok, start_mem;
  logic [MPU_REGIONS-1:0] mpu_hit;
  logic [31:0] sr_rdata, cfg0, st_data, st_lane;
  logic [3:0]  be_eff;
  assign cls  = cca_pkg::cca_insn_t'(INSN_CLASS_I);
  assign take = INSN_VALID_I && (state_reg == cca_pkg::CCA_IDLE);
  assign is_dw = (cls == cca_pkg::CCA_LOAD_D) || (cls == cca_pkg::CCA_STORE_D);
  assign is_wr = (cls == cca_pkg::CCA_STORE) || (cls == cca_pkg::CCA_STORE_D);
  assign is_mem = is_dw || is_wr || (cls == cca_pkg::CCA_LOAD);
  // No bytecode, translation or cache hardware exists here [RULE5] [RULE11]
  assign unimpl = (cls == cca_pkg::CCA_SIMD) || (cls == cca_pkg::CCA_BYTECODE)
                || (cls == cca_pkg::CCA_TLB) || (cls == cca_pkg::CCA_CACHE)
                || ((cls == cca_pkg::CCA_COPRO) && !COPRO_PRESENT_I);
  // Double words check word alignment only [RULE9]
  assign size_eff = is_dw ? cca_pkg::CCA_WORD : cca_pkg::cca_size_t'(ACC_SIZE_I);
  // Natural alignment for everything else [RULE10]
  assign misalign = is_mem && (((size_eff == cca_pkg::CCA_HALF) && ACC_ADDR_I[0])
                || ((size_eff == cca_pkg::CCA_WORD) && (ACC_ADDR_I[1:0] != 2'h0)));
  // Address decode picks the path from a plain load/store [RULE4] [RULE8]
  assign in_ram = (ACC_ADDR_I & `CCA_RAM_MASK) == `CCA_RAM_BASE;
  assign in_lb  = (ACC_ADDR_I & `CCA_LB_MASK) == `CCA_LB_BASE;

  // Protection: a region hits when its valid bit is set and the address
  // lies within the power-of-two span given by bits 5:1 [RULE5]
  genvar g;
  generate
    for (g = 0; g < MPU_REGIONS; g++) begin : g_mpu
      logic [31:0] span_mask;
      assign span_mask  = ~((32'h0000_0001 << mpuar_reg[g][5:1]) - 32'h0000_0001);
      assign mpu_hit[g] = mpuar_reg[g][0] && ((ACC_ADDR_I & span_mask)
                        == (mpuar_reg[g] & `CCA_MPU_BASE_MASK & span_mask));
    end
  endgenerate
  assign mpu_ok = !mpen_reg || (|mpu_hit);

  // Only a clean access starts; a fault changes nothing [RULE13] [RULE6]
  assign start_mem = take && is_mem && !misalign && mpu_ok && !(in_lb && !lben_reg);

  // Store lanes replicated so any byte enable sees its data
  assign st_data = rf_reg[ACC_SRC_I];
  assign st_lane = (size_eff == cca_pkg::CCA_BYTE) ? {4{st_data[7:0]}}
                 : (size_eff == cca_pkg::CCA_HALF) ? {2{st_data[15:0]}} : st_data;
  assign be_eff  = (size_eff == cca_pkg::CCA_BYTE) ? (4'h1 << ACC_ADDR_I[1:0])
                 : (size_eff == cca_pkg::CCA_HALF) ? (ACC_ADDR_I[1] ? 4'hC : 4'h3)
                 : 4'hF;

  // System register read: revision field is hardwired, writes ignored [RULE12]
  assign cfg0 = 32'(`CCA_ARCH_REV) << `CCA_CFG0_REV_LSB;
  assign sr_rdata = (ACC_ADDR_I[9:0] == `CCA_SR_CFG0) ? cfg0
                  : (ACC_ADDR_I[9:0] == `CCA_SR_CPU_CONTROL_REGISTER)
                    ? ((32'(mpen_reg) << `CCA_CPU_CONTROL_REGISTER_MPEN) | (32'(lben_reg) << `CCA_CPU_CONTROL_REGISTER_LBEN))
                  : 32'h0000_0000;

  // Transfer completion per path
  logic        core_ram, xfer_end, more;
  logic [31:0] rsel, rshift, load_val;
  assign core_ram = (state_reg == cca_pkg::CCA_ISSUE) && (tgt_reg == cca_pkg::CCA_T_RAM);
  // Local bus answers in the same cycle, no wait state [RULE7]
  assign xfer_end = (state_reg == cca_pkg::CCA_RDATA)
                  || ((state_reg == cca_pkg::CCA_ISSUE) && ((tgt_reg == cca_pkg::CCA_T_LB)
                  || (core_ram && we_reg)
                  || ((tgt_reg == cca_pkg::CCA_T_HSB) && HSBD_READY_I)));
  assign more = dw_reg && !second_reg;
  assign rsel = (state_reg == cca_pkg::CCA_RDATA) ? RAM_RDATA_I
              : (tgt_reg == cca_pkg::CCA_T_LB) ? LB_RDATA_I : HSBD_RDATA_I;
  assign rshift = rsel >> {addr_reg[1:0], 3'h0};
  // Sub-word loads are zero extended
  assign load_val = (size_reg == 2'h0) ? {24'h00_0000, rshift[7:0]}
                  : (size_reg == 2'h1) ? {16'h0000, rshift[15:0]} : rshift;

  // One explicit register write per cycle: load or mfsr result
  logic        wb_en, fetch_fire;
  logic [3:0]  wb_idx;
  logic [31:0] wb_data;
  assign wb_en   = (xfer_end && !we_reg) || (take && (cls == cca_pkg::CCA_MFSR));
  assign wb_idx  = (state_reg == cca_pkg::CCA_IDLE) ? ACC_DST_I : dst_reg;
  assign wb_data = (state_reg == cca_pkg::CCA_IDLE) ? sr_rdata : load_val;
  assign fetch_fire = FETCH_EN_I && IF_READY_I;

  // Register file: explicit write wins, then implicit return value,
  // then fetch advance of the program counter [RULE1] [RULE2]
  generate
    for (g = 0; g < `CCA_RF_ENTRIES; g++) begin : g_rf
      localparam logic [3:0] IDX = 4'(g);
      assign rf_next[g] = (wb_en && (wb_idx == IDX)) ? wb_data
                        : (RETVAL_WE_I && (IDX == `CCA_RETVAL_IDX)) ? RETVAL_DATA_I
                        : (fetch_fire && (IDX == `CCA_PC_IDX)) ? rf_reg[g] + `CCA_PC_STEP
                        : rf_reg[g];
      // Entry update
      always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
          rf_reg[g] <= (IDX == `CCA_PC_IDX) ? `CCA_PC_RESET : 32'h0000_0000;
        end else begin
          rf_reg[g] <= rf_next[g];
        end
      end
    end
  endgenerate

  // System register writes: enable bits and protection regions
  logic sr_we;
  assign sr_we = take && (cls == cca_pkg::CCA_MTSR);
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      lben_reg <= 1'b0;     // Local bus off until software opens it
      mpen_reg <= 1'b0;
    end else if (sr_we && (ACC_ADDR_I[9:0] == `CCA_SR_CPU_CONTROL_REGISTER)) begin
      lben_reg <= st_data[`CCA_CPU_CONTROL_REGISTER_LBEN];   // [RULE6]
      mpen_reg <= st_data[`CCA_CPU_CONTROL_REGISTER_MPEN];
    end
  end
  generate
    for (g = 0; g < MPU_REGIONS; g++) begin : g_mpuw
      // Region descriptor write
      always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
          mpuar_reg[g] <= 32'h0000_0000;
        end else if (sr_we && (ACC_ADDR_I[9:0] == `CCA_SR_MPUAR0 + 10'(4 * g))) begin
          mpuar_reg[g] <= st_data;
        end
      end
    end
  endgenerate

  // Sequencer: decode, issue, wait, then upper word for double transfers
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      state_reg  <= cca_pkg::CCA_IDLE;
      tgt_reg    <= cca_pkg::CCA_T_RAM;
      addr_reg   <= 32'h0000_0000;
      wdata_reg  <= 32'h0000_0000;
      be_reg     <= 4'h0;
      dst_reg    <= 4'h0;
      src_reg    <= 4'h0;
      size_reg   <= 2'h0;
      we_reg     <= 1'b0;
      dw_reg     <= 1'b0;
      second_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        cca_pkg::CCA_IDLE: begin
          if (start_mem) begin
            state_reg  <= cca_pkg::CCA_ISSUE;
            tgt_reg    <= in_lb ? cca_pkg::CCA_T_LB
                        : in_ram ? cca_pkg::CCA_T_RAM : cca_pkg::CCA_T_HSB;
            addr_reg   <= ACC_ADDR_I;
            wdata_reg  <= st_lane;
            be_reg     <= be_eff;
            dst_reg    <= ACC_DST_I;
            src_reg    <= ACC_SRC_I;
            size_reg   <= size_eff;
            we_reg     <= is_wr;
            dw_reg     <= is_dw;
            second_reg <= 1'b0;
          end else if (take && !is_mem && !unimpl) begin
            done_reg <= 1'b1;   // Nop and system register moves retire now
          end
        end
        cca_pkg::CCA_ISSUE, cca_pkg::CCA_RDATA: begin
          if (core_ram && !we_reg) begin
            state_reg <= cca_pkg::CCA_RDATA;   // RAM data one cycle later
          end else if (xfer_end && more) begin
            // Upper word: next address, paired register [RULE9]
            state_reg  <= cca_pkg::CCA_ISSUE;
            second_reg <= 1'b1;
            addr_reg   <= addr_reg + `CCA_DW_STEP;
            dst_reg    <= dst_reg + 4'h1;
            wdata_reg  <= rf_reg[src_reg + 4'h1];
          end else if (xfer_end) begin
            state_reg <= cca_pkg::CCA_IDLE;
            done_reg  <= 1'b1;
          end
        end
        default: state_reg <= cca_pkg::CCA_IDLE;
      endcase
    end
  end

  // Exception pulses, one cycle after the offending instruction
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      exc_unimpl_reg <= 1'b0;
      exc_align_reg  <= 1'b0;
      exc_prot_reg   <= 1'b0;
      exc_lboff_reg  <= 1'b0;
      exc_addr_reg   <= 32'h0000_0000;
    end else begin
      exc_unimpl_reg <= take && unimpl;                         // [RULE11]
      exc_align_reg  <= take && is_mem && misalign;             // [RULE13]
      exc_prot_reg   <= take && is_mem && !misalign && !mpu_ok;
      exc_lboff_reg  <= take && is_mem && !misalign && mpu_ok && in_lb && !lben_reg;
      if (take && is_mem && (misalign || !mpu_ok || (in_lb && !lben_reg))) begin
        exc_addr_reg <= ACC_ADDR_I;
      end
    end
  end

  // Fetch master and slave read return
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      fetch_data_reg  <= 32'h0000_0000;
      fetch_valid_reg <= 1'b0;
      hsbs_rvalid_reg <= 1'b0;
    end else begin
      fetch_valid_reg <= fetch_fire;
      if (fetch_fire) begin
        fetch_data_reg <= IF_RDATA_I;
      end
      hsbs_rvalid_reg <= HSBS_SEL_I && !core_ram && !HSBS_WE_I;
    end
  end

  // Three bus interfaces: fetch master, data master, RAM slave [RULE3]
  assign IF_REQ_O      = FETCH_EN_I;
  assign IF_ADDR_O     = rf_reg[`CCA_PC_IDX];
  assign FETCH_DATA_O  = fetch_data_reg;
  assign FETCH_VALID_O = fetch_valid_reg;
  assign HSBD_REQ_O = (state_reg == cca_pkg::CCA_ISSUE) && (tgt_reg == cca_pkg::CCA_T_HSB);
  assign LB_REQ_O   = (state_reg == cca_pkg::CCA_ISSUE) && (tgt_reg == cca_pkg::CCA_T_LB);
  assign MEM_WE_O    = we_reg;
  assign MEM_ADDR_O  = addr_reg;
  assign MEM_BE_O    = be_reg;
  assign MEM_WDATA_O = wdata_reg;
  // Core owns the RAM port when it needs it; the slave then stalls.
  // Giving the core priority keeps its RAM latency fixed [RULE4]
  assign RAM_REQ_O    = core_ram || HSBS_SEL_I;
  assign RAM_WE_O     = core_ram ? we_reg : HSBS_WE_I;
  assign RAM_ADDR_O   = core_ram ? addr_reg : HSBS_ADDR_I;
  assign RAM_BE_O     = core_ram ? be_reg : HSBS_BE_I;
  assign RAM_WDATA_O  = core_ram ? wdata_reg : HSBS_WDATA_I;
  assign HSBS_READY_O  = !core_ram;
  assign HSBS_RVALID_O = hsbs_rvalid_reg;
  assign HSBS_RDATA_O  = RAM_RDATA_I;
  // Status and exceptions
  assign BUSY_O       = state_reg != cca_pkg::CCA_IDLE;
  assign DONE_O       = done_reg;
  assign EXC_UNIMPL_O = exc_unimpl_reg;
  assign EXC_ALIGN_O  = exc_align_reg;
  assign EXC_PROT_O   = exc_prot_reg;
  assign EXC_LBOFF_O  = exc_lboff_reg;
  assign EXC_ADDR_O   = exc_addr_reg;
  assign RETVAL_O     = rf_reg[`CCA_RETVAL_IDX];

endmodule : cca_core

/* File: verif/cca_core_checker.sv */
// Port-level assertions for the core access unit.
// Assumes a bind into cca_core and the constants of cca_map.svh.
`timescale 1ns/10ps
`include "cca_map.svh"
module cca_core_checker #(
  parameter int MPU_REGIONS = 8            // Same region count as the core
) (
  input wire logic        CLK_SYS_I,
  input wire logic        RST_B_I,
  input wire logic        INSN_VALID_I,
  input wire logic [3:0]  INSN_CLASS_I,
  input wire logic [1:0]  ACC_SIZE_I,
  input wire logic [31:0] ACC_ADDR_I,
  input wire logic [3:0]  ACC_DST_I,
  input wire logic        COPRO_PRESENT_I,
  input wire logic        BUSY_O,
  input wire logic        DONE_O,
  input wire logic        EXC_UNIMPL_O,
  input wire logic        EXC_ALIGN_O,
  input wire logic        EXC_LBOFF_O,
  input wire logic        RETVAL_WE_I,
  input wire logic [31:0] RETVAL_DATA_I,
  input wire logic [31:0] RETVAL_O,
  input wire logic        IF_REQ_O,
  input wire logic        IF_READY_I,
  input wire logic [31:0] IF_ADDR_O,
  input wire logic        FETCH_VALID_O,
  input wire logic        LB_REQ_O,
  input wire logic        HSBD_REQ_O,
  input wire logic [31:0] MEM_ADDR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  // Decode of the offered instruction
  wire take    = INSN_VALID_I && !BUSY_O;
  wire memop   = INSN_CLASS_I inside {cca_pkg::CCA_LOAD, cca_pkg::CCA_STORE};
  wire dwop    = INSN_CLASS_I inside {cca_pkg::CCA_LOAD_D, cca_pkg::CCA_STORE_D};
  wire mis     = (ACC_SIZE_I == 2'h2 && ACC_ADDR_I[1:0] != 2'h0) ||
                 (ACC_SIZE_I == 2'h1 && ACC_ADDR_I[0]);
  wire lb_rng  = (ACC_ADDR_I & `CCA_LB_MASK) == `CCA_LB_BASE;
  // Coprocessor counts only when absent
  wire no_impl = INSN_CLASS_I inside {cca_pkg::CCA_SIMD, cca_pkg::CCA_BYTECODE,
                 cca_pkg::CCA_TLB, cca_pkg::CCA_CACHE} ||
                 (INSN_CLASS_I == cca_pkg::CCA_COPRO && !COPRO_PRESENT_I);
  // Word load into the local range, then its strobe
  sequence s_lb_load;
    take && INSN_CLASS_I == cca_pkg::CCA_LOAD && ACC_SIZE_I == 2'h2 && !mis && lb_rng
      ##1 LB_REQ_O;
  endsequence
  sequence s_misalign;
    take && memop && mis;
  endsequence
  a_unimpl_trap: assert property (take && no_impl |=> EXC_UNIMPL_O && !DONE_O)
    else $error("unimplemented class not trapped");
  a_load_legal: assert property (take && memop |=> !EXC_UNIMPL_O)
    else $error("load or store trapped as unimplemented");
  a_align_trap: assert property (s_misalign |=> EXC_ALIGN_O)
    else $error("misaligned access not trapped");
  a_align_abort: assert property (s_misalign |=> !LB_REQ_O && !HSBD_REQ_O && !DONE_O)
    else $error("misaligned access was performed");
  a_dw_word_ok: assert property (take && dwop && ACC_ADDR_I[1:0] == 2'h0 |=> !EXC_ALIGN_O)
    else $error("word aligned double transfer trapped");
  a_lb_range: assert property (LB_REQ_O |-> (MEM_ADDR_O & `CCA_LB_MASK) == `CCA_LB_BASE)
    else $error("local strobe outside local range");
  a_lb_gate: assert property (take && memop && !mis && lb_rng |=> LB_REQ_O != EXC_LBOFF_O)
    else $error("local access neither done nor refused");
  a_lb_single: assert property (s_lb_load |=> DONE_O && !BUSY_O && !LB_REQ_O)
    else $error("local transfer took more than one cycle");
  a_retval_write: assert property (RETVAL_WE_I && !BUSY_O && !INSN_VALID_I |=>
    RETVAL_O == $past(RETVAL_DATA_I))
    else $error("return value register not written");
  a_rev_field: assert property (take && INSN_CLASS_I == cca_pkg::CCA_MFSR &&
    ACC_ADDR_I[9:0] == `CCA_SR_CFG0 && ACC_DST_I == `CCA_RETVAL_IDX |=>
    RETVAL_O[15:13] == `CCA_ARCH_REV)
    else $error("architecture revision field wrong");
  a_fetch_step: assert property (IF_REQ_O && IF_READY_I |=>
    FETCH_VALID_O && IF_ADDR_O == $past(IF_ADDR_O) + `CCA_PC_STEP)
    else $error("fetch did not advance the program counter");
endmodule : cca_core_checker

/* File: verif/cca_mem_model.sv */
// Far side of the core: local bus slave, data RAM, data and fetch buses.
// Assumes the bench samples 2 ns after the rising edge.
`timescale 1ns/10ps
module cca_mem_model (
  input  wire logic        clk_i,
  input  wire logic        lb_req_i,
  input  wire logic [31:0] mem_addr_i,
  output logic      [31:0] lb_rdata_o,
  input  wire logic        ram_req_i,
  input  wire logic        ram_we_i,
  input  wire logic [31:0] ram_addr_i,
  output logic      [31:0] ram_rdata_o,
  output logic             hsbd_ready_o,
  output logic      [31:0] hsbd_rdata_o,
  output logic             if_ready_o,
  input  wire logic [31:0] if_addr_i,
  output logic      [31:0] if_rdata_o
);
  integer      seed     = 85681;           // Own stall stream
  logic [31:0] junk_reg = 32'h0;           // Changes every cycle off-transfer
  logic [31:0] ram_q_reg;                  // RAM word for next cycle
  logic        ram_rd_reg = 1'b0;          // RAM read answered this cycle
  // Word content derived from its address
  function automatic logic [31:0] pat(input logic [31:0] x);
    return {x[31:2], 2'b00} ^ 32'h5A3C_96E1;
  endfunction : pat
  // Local slave answers in the strobe cycle itself
  assign lb_rdata_o   = lb_req_i ? pat(mem_addr_i) : junk_reg;
  // RAM read data one cycle after the request
  assign ram_rdata_o  = ram_rd_reg ? ram_q_reg : ~junk_reg;
  // Bus data only meaningful with ready
  assign hsbd_rdata_o = hsbd_ready_o ? pat(mem_addr_i) : junk_reg;
  assign if_rdata_o   = if_ready_o ? pat(if_addr_i) : ~junk_reg;
  // Random stalls keep both masters waiting some cycles
  always @(posedge clk_i) begin
    junk_reg   <= junk_reg + 32'h9E37_79B9;
    ram_rd_reg <= ram_req_i && !ram_we_i;
    ram_q_reg  <= pat(ram_addr_i);
    #1;
    hsbd_ready_o = ($random(seed) & 1) == 1;
    if_ready_o   = ($random(seed) & 1) == 1;
  end
endmodule : cca_mem_model

/* File: verif/cca_core_bench.sv */
// Self-checking bench for the core access unit with random addresses.
// Assumes cca_mem_model as far side and the checker bound below.
`timescale 1ns/10ps
`include "cca_map.svh"
bind cca_core cca_core_checker #(.MPU_REGIONS(MPU_REGIONS)) i_chk (.*);
module cca_core_bench;
  logic RST_B_I = 1'b0, INSN_VALID_I = 1'b0, COPRO_PRESENT_I = 1'b0, RETVAL_WE_I = 1'b0;
  logic FETCH_EN_I = 1'b0, HSBS_SEL_I = 1'b0, HSBS_WE_I = 1'b0, CLK_SYS_I = 1'b0;
  logic [3:0] INSN_CLASS_I = 4'h0, ACC_SRC_I = 4'h0, ACC_DST_I = 4'h0, HSBS_BE_I = 4'hF;
  logic [1:0] ACC_SIZE_I = 2'h0;
  logic [31:0] ACC_ADDR_I = 32'h0, RETVAL_DATA_I = 32'h0, HSBS_ADDR_I = 32'h0;
  logic [31:0] HSBS_WDATA_I = 32'h0, IF_RDATA_I, HSBD_RDATA_I, LB_RDATA_I, RAM_RDATA_I;
  logic [31:0] EXC_ADDR_O, RETVAL_O, IF_ADDR_O, FETCH_DATA_O, MEM_ADDR_O, MEM_WDATA_O;
  logic [31:0] RAM_ADDR_O, RAM_WDATA_O, HSBS_RDATA_O;
  logic [3:0]  MEM_BE_O, RAM_BE_O;
  logic BUSY_O, DONE_O, EXC_UNIMPL_O, EXC_ALIGN_O, EXC_PROT_O, EXC_LBOFF_O, IF_REQ_O;
  logic FETCH_VALID_O, HSBD_REQ_O, LB_REQ_O, MEM_WE_O, RAM_REQ_O, RAM_WE_O, IF_READY_I;
  logic HSBD_READY_I, HSBS_READY_O, HSBS_RVALID_O;
  integer      seed, errors, cmp_count, t;
  logic [31:0] eu, ea, el, dn, a, rv;      // Flags after a take, address, value
  logic [31:0] base [3] = '{`CCA_RAM_BASE, `CCA_LB_BASE, 32'h4000_0000};
  logic [3:0]  ucls [5] = '{cca_pkg::CCA_SIMD, cca_pkg::CCA_COPRO, cca_pkg::CCA_BYTECODE,
                            cca_pkg::CCA_TLB, cca_pkg::CCA_CACHE};
  cca_core i_dut (.*);
  cca_mem_model i_mem (.clk_i(CLK_SYS_I), .lb_req_i(LB_REQ_O), .mem_addr_i(MEM_ADDR_O),
    .lb_rdata_o(LB_RDATA_I), .ram_req_i(RAM_REQ_O), .ram_we_i(RAM_WE_O),
    .ram_addr_i(RAM_ADDR_O), .ram_rdata_o(RAM_RDATA_I), .hsbd_ready_o(HSBD_READY_I),
    .hsbd_rdata_o(HSBD_RDATA_I), .if_ready_o(IF_READY_I), .if_addr_i(IF_ADDR_O),
    .if_rdata_o(IF_RDATA_I));
  // 20 MHz system clock
  initial begin
    forever #25 CLK_SYS_I = ~CLK_SYS_I;
  end
  // Expected word at an address
  function automatic logic [31:0] pat(input logic [31:0] x);
    return {x[31:2], 2'b00} ^ 32'h5A3C_96E1;
  endfunction : pat
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk
  task automatic results;
    $display("Comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // Offer one instruction, then wait bounded until the core is idle
  task automatic issue(input logic [3:0] c, input logic [1:0] s, input logic [31:0] ad,
                       input logic [3:0] sr, input logic [3:0] ds);
    int n;
    n = 0;
    do begin
      @(posedge CLK_SYS_I);
      #2;
      n++;
    end while (BUSY_O !== 1'b0 && n < 64);
    INSN_VALID_I = 1'b1;
    INSN_CLASS_I = c;
    ACC_SIZE_I   = s;
    ACC_ADDR_I   = ad;
    ACC_SRC_I    = sr;
    ACC_DST_I    = ds;
    @(posedge CLK_SYS_I);
    #2;
    INSN_VALID_I = 1'b0;
    eu = {31'h0, EXC_UNIMPL_O};
    ea = {31'h0, EXC_ALIGN_O};
    el = {31'h0, EXC_LBOFF_O};
    dn = {31'h0, DONE_O};
    while (BUSY_O !== 1'b0 && n < 64) begin
      @(posedge CLK_SYS_I);
      #2;
      n++;
      dn = dn | {31'h0, DONE_O};
    end
    if (n >= 64) begin
      $display("Error wait_idle expected idle seen busy");
      errors++;
      results();
    end
  endtask : issue
  // Implicit write of the return value register
  task automatic setrv(input logic [31:0] v);
    RETVAL_WE_I   = 1'b1;
    RETVAL_DATA_I = v;
    @(posedge CLK_SYS_I);
    #2;
    RETVAL_WE_I   = 1'b0;
  endtask : setrv
  initial begin
    seed = 85681;
    errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge CLK_SYS_I);
    #2;
    RST_B_I = 1'b1;
    chk("if_addr", `CCA_PC_RESET, IF_ADDR_O);
    // Every unimplemented class, then coprocessor fitted
    for (t = 0; t < 7; t++) begin
      COPRO_PRESENT_I = t > 5;
      issue(ucls[t % 5], 2'h2, 32'h0, 4'h0, 4'h3);
      chk("exc_unimpl", {31'h0, t < 6}, eu);
    end
    // Local range refused until enabled
    setrv(32'h0000_0001);
    a = `CCA_LB_BASE | ($random(seed) & 32'h0000_FFFC);
    issue(cca_pkg::CCA_LOAD, 2'h2, a, 4'h0, 4'hC);
    chk("exc_lboff", 32'h1, el);
    chk("retval", 32'h1, RETVAL_O);
    issue(cca_pkg::CCA_MTSR, 2'h2, {22'h0, `CCA_SR_CPU_CONTROL_REGISTER}, 4'hC, 4'h0);
    // Word loads into RAM, local bus and bus ranges
    for (t = 0; t < 9; t++) begin
      a = base[t % 3] | ($random(seed) & 32'h0000_FFFC);
      issue(cca_pkg::CCA_LOAD, 2'h2, a, 4'h0, 4'hC);
      chk("load_done", 32'h1, dn);
      chk("load_data", pat(a), RETVAL_O);
    end
    // Double words at word-only alignment, upper word lands in reg 12
    for (t = 0; t < 3; t++) begin
      a = base[t] | ($random(seed) & 32'h0000_7FF8) | 32'h4;
      issue(cca_pkg::CCA_LOAD_D, 2'h2, a, 4'h0, 4'hB);
      chk("dw_align", 32'h0, ea);
      chk("dw_upper", pat(a + `CCA_DW_STEP), RETVAL_O);
    end
    // Misaligned word and half accesses change nothing
    for (t = 0; t < 6; t++) begin
      rv = $random(seed);
      setrv(rv);
      a = base[t % 3] | ($random(seed) & 32'h0000_FFFC) | ((t % 3) + 1);
      issue(t % 2 ? cca_pkg::CCA_STORE : cca_pkg::CCA_LOAD, t < 3 ? 2'h2 : 2'h1,
            t < 3 ? a : a | 32'h1, 4'hC, 4'hC);
      chk("exc_align", 32'h1, ea);
      chk("retval", rv, RETVAL_O);
    end
    chk("exc_addr", a | 32'h1, EXC_ADDR_O);
    issue(cca_pkg::CCA_LOAD, 2'h0, a | 32'h3, 4'h0, 4'h3);
    chk("byte_align", 32'h0, ea);
    issue(cca_pkg::CCA_MFSR, 2'h2, {22'h0, `CCA_SR_CFG0}, 4'h0, 4'hC);
    chk("arch_rev", {29'h0, `CCA_ARCH_REV}, {29'h0, RETVAL_O[15:13]});
    // Fetch master under random stalls
    a = `CCA_PC_RESET;
    FETCH_EN_I = 1'b1;
    for (t = 0; t < 24; t++) begin
      if (IF_READY_I === 1'b1) begin
        rv = pat(a);
        a = a + `CCA_PC_STEP;
      end
      @(posedge CLK_SYS_I);
      #2;
    end
    FETCH_EN_I = 1'b0;
    chk("fetch_pc", a, IF_ADDR_O);
    chk("fetch_data", rv, FETCH_DATA_O);
    // Another master reads the internal RAM
    a = $random(seed) & 32'h0000_FFFC;
    HSBS_ADDR_I = a;
    HSBS_SEL_I = 1'b1;
    @(posedge CLK_SYS_I);
    #2;
    HSBS_SEL_I = 1'b0;
    chk("slave_rvalid", 32'h1, {31'h0, HSBS_RVALID_O});
    chk("slave_rdata", pat(a), HSBS_RDATA_O);
    results();
  end
endmodule : cca_core_bench
